/* include/sdcl_consts.vh */
// constants for the serial dac code loader
`ifndef SDCL_CONSTS_VH
`define SDCL_CONSTS_VH
`define SDCL_WORD_BITS 8
`define SDCL_CNT_W 4
`define SDCL_CODE_RST 8'h00
`define SDCL_SHIFT_RST 8'h00
`define SDCL_CNT_RST 4'h0
`define SDCL_MSB 7
`define SDCL_LAST_CNT 4'h7
`define SDCL_FULL_CNT 4'h8
`define SDCL_CNT_ONE 4'h1
`define SDCL_FLAG_RST 1'b0
`define SDCL_SYNC_RST_HI 1'b1
`define SDCL_SYNC_RST_LO 1'b0
`endif

/* verilog/sdcl_serial_dac_code_loader.v */
// serial front end that loads an 8-bit code into the dac register
// What this block does
// R1 - one frame carries exactly eight data bits
// R2 - bits only accepted while frame select low
// R3 - frame select edges bound and enable frames
// R4 - host lowers frame select before first clock
// R5 - capture one bit per serial clock fall
// R6 - host raises frame select after eighth bit
// R7 - load low after full word updates dac
// R8 - host may hold load permanently low
// R9 - load held low: update after eighth fall
// R10 - new frame needs a fresh select fall
// R11 - interface powers up on select fall
// R12 - input buffers power down on select rise
// R13 - dac register holds straight binary code
// R14 - first bit captured becomes code bit seven
// R15 - reset clears shift and dac registers
`include "sdcl_consts.vh"
`default_nettype none

// two-stage synchroniser with one extra stage for edge finding
module sdcl_sync #(
	parameter [0:0] RST_VAL = 1'b0
) (
	input  wire clock,
	input  wire rst_n,
	input  wire d_in,
	output reg  q_sync_r,
	output reg  q_prev_r
);
	reg meta_r;

	// meta_r is read by q_sync_r alone
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r   <= RST_VAL;
			q_sync_r <= RST_VAL;
			q_prev_r <= RST_VAL;
		end else begin
			meta_r   <= d_in;
			q_sync_r <= meta_r;
			q_prev_r <= q_sync_r;
		end
	end
endmodule // sdcl_sync

module sdcl_serial_dac_code_loader (
	input  wire       clock,
	input  wire       nrst,
	input  wire       serial_clk,
	input  wire       serial_data_in,
	input  wire       frame_sel_n,
	input  wire       load_dac_n,
	output reg  [7:0] dac_code_r,
	output reg        if_powered_r,
	output reg        word_ready_r
);
	reg        rst_meta_r;
	reg        rst_n_r;
	reg  [7:0] shift_r;
	reg  [3:0] bit_cnt_r;
	reg        full_r;
	reg  [7:0] shift_nxt;
	reg  [3:0] bit_cnt_nxt;
	reg        full_nxt;
	reg        ready_nxt;
	reg        powered_nxt;
	reg  [7:0] code_nxt;
	wire       sclk_s;
	wire       sclk_prev;
	wire       serial_data_in_s;
	wire       fsel_s;
	wire       fsel_prev;
	wire       load_dac_n_s;
	wire       load_dac_n_prev;
	wire       sclk_fall;
	wire       fsel_fall;
	wire       fsel_rise;
	wire       fsel_low;
	wire       load_dac_n_fall;
	wire       load_dac_n_low;
	wire       last_bit;
	wire       room_left;
	wire       take_bit;
	wire [7:0] shift_in;

	// reset enters asynchronously but is released on the clock
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= `SDCL_FLAG_RST;
			rst_n_r    <= `SDCL_FLAG_RST;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// every pin passes two flops before any logic reads it
	// serial clock idles high, so its stages reset high: no false fall
	sdcl_sync #(
		.RST_VAL (`SDCL_SYNC_RST_HI)
	) u_sclk_sync (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.d_in     (serial_clk),
		.q_sync_r (sclk_s),
		.q_prev_r (sclk_prev)
	);

	// data feeds the shifter only; its edges are not needed
	sdcl_sync #(
		.RST_VAL (`SDCL_SYNC_RST_LO)
	) u_serial_data_in_sync (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.d_in     (serial_data_in),
		.q_sync_r (serial_data_in_s),
		.q_prev_r ()
	);

	sdcl_sync #(
		.RST_VAL (`SDCL_SYNC_RST_HI)
	) u_fsel_sync (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.d_in     (frame_sel_n),
		.q_sync_r (fsel_s),
		.q_prev_r (fsel_prev)
	);

	sdcl_sync #(
		.RST_VAL (`SDCL_SYNC_RST_HI)
	) u_load_dac_n_sync (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.d_in     (load_dac_n),
		.q_sync_r (load_dac_n_s),
		.q_prev_r (load_dac_n_prev)
	);

	assign sclk_fall = sclk_prev & ~sclk_s; // R5
	assign fsel_fall = fsel_prev & ~fsel_s; // R3
	assign fsel_rise = ~fsel_prev & fsel_s; // R3
	assign fsel_low  = ~fsel_s; // R2
	assign load_dac_n_fall = load_dac_n_prev & ~load_dac_n_s; // R7
	assign load_dac_n_low  = ~load_dac_n_s; // R9
	assign last_bit  = (bit_cnt_r == `SDCL_LAST_CNT); // R1
	assign room_left = (bit_cnt_r < `SDCL_FULL_CNT); // R1
	// msb first: new bit enters at bit zero and walks up to bit seven
	assign shift_in  = {shift_r[`SDCL_MSB-1:0], serial_data_in_s}; // R14
	// select edges win over a serial edge in the same cycle
	assign take_bit  = if_powered_r & fsel_low & sclk_fall & room_left &
		~fsel_fall & ~fsel_rise; // R2

	always @* begin
		bit_cnt_nxt = bit_cnt_r;
		powered_nxt = if_powered_r;
		if (fsel_fall) begin
			powered_nxt = 1'b1; // R11
			bit_cnt_nxt = `SDCL_CNT_RST; // R10
		end else if (fsel_rise) begin
			powered_nxt = 1'b0; // R12
			bit_cnt_nxt = `SDCL_CNT_RST; // R3
		end else if (take_bit) begin
			bit_cnt_nxt = bit_cnt_r + `SDCL_CNT_ONE;
		end
	end

	// the full flag outlives the frame, so a late load still finds its word
	always @* begin
		shift_nxt = shift_r;
		full_nxt  = full_r;
		ready_nxt = word_ready_r;
		if (take_bit) begin
			shift_nxt = shift_in; // R5
			full_nxt  = last_bit; // R1
			ready_nxt = last_bit;
		end
	end

	// a load edge in the same cycle as the eighth bit takes the new word
	always @* begin
		code_nxt = dac_code_r;
		if (take_bit && last_bit && load_dac_n_low) begin
			code_nxt = shift_in; // R9
		end else if (load_dac_n_fall && full_r) begin
			code_nxt = shift_r; // R7
		end
	end

	// frame bookkeeping: bit count and interface power
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bit_cnt_r    <= `SDCL_CNT_RST;
			if_powered_r <= `SDCL_FLAG_RST;
		end else begin
			bit_cnt_r    <= bit_cnt_nxt;
			if_powered_r <= powered_nxt;
		end
	end

	// word capture
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			shift_r      <= `SDCL_SHIFT_RST; // R15
			full_r       <= `SDCL_FLAG_RST;
			word_ready_r <= `SDCL_FLAG_RST;
		end else begin
			shift_r      <= shift_nxt;
			full_r       <= full_nxt;
			word_ready_r <= ready_nxt;
		end
	end

	// the dac register only ever holds a complete straight binary word
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dac_code_r <= `SDCL_CODE_RST; // R15
		end else begin
			dac_code_r <= code_nxt; // R13
		end
	end
endmodule // sdcl_serial_dac_code_loader
`default_nettype wire

/* verif/sdcl_asserts.sv */
// checker for the dac code loader
`default_nettype none
module sdcl_asserts (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       frame_sel_n,
	input wire logic       load_dac_n,
	input wire logic       if_powered_r,
	input wire logic       word_ready_r,
	input wire logic [7:0] dac_code_r
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	sequence s_sel_low;
		!frame_sel_n [*5];
	endsequence
	sequence s_sel_high;
		frame_sel_n [*5];
	endsequence
	property p_upd;
		$changed(dac_code_r) |-> word_ready_r;
	endproperty
	a_upd: assert property (p_upd) else $error("early update");
	property p_on;
		s_sel_low |-> if_powered_r;
	endproperty
	a_on: assert property (p_on) else $error("not powered");
	property p_off;
		s_sel_high |-> !if_powered_r;
	endproperty
	a_off: assert property (p_off) else $error("still powered");
	property p_sel;
		$rose(word_ready_r) |-> $past(if_powered_r);
	endproperty
	a_sel: assert property (p_sel) else $error("idle bits");
	property p_quiet;
		s_sel_high |-> $stable(word_ready_r);
	endproperty
	a_quiet: assert property (p_quiet) else $error("bits taken while closed");
	property p_load_low;
		$changed(dac_code_r) |-> $past(!load_dac_n, 3);
	endproperty
	a_load_low: assert property (p_load_low) else $error("update without load");
endmodule // sdcl_asserts
bind sdcl_serial_dac_code_loader sdcl_asserts u_chk(.*);
`default_nettype wire

/* verif/sdcl_host.sv */
// host serial port model
`default_nettype none
module sdcl_host (
	output logic sclk,
	output logic sdi,
	output logic fs_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// link idles with its clock high and the frame closed
	initial begin
		sclk = 1'b1;
		sdi  = 1'b0;
		fs_n = 1'b1;
	end
	// called on a system clock edge: the 1 ns lead and 62.5 ns steps
	// keep every change clear of the sampling edges
	task send(input logic [7:0] w);
		#1 fs_n = 1'b0;
		#62.5;
		for (int i = 7; i >= 0; i--) begin
			sdi = w[i];
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		fs_n = 1'b1;
		sdi  = ~sdi;
		#100;
	endtask
	// clock pulses with the frame closed must be ignored
	task stray(input logic [7:0] w);
		#1;
		for (int i = 7; i >= 0; i--) begin
			sdi = w[i];
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#100;
	endtask
endmodule // sdcl_host
`default_nettype wire

/* verif/sdcl_serial_dac_code_loader_tb.sv */
// bench for the dac code loader
`default_nettype none
module sdcl_serial_dac_code_loader_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock = 1'b0;
	logic       nrst = 1'b0;
	logic       ld_n = 1'b0;
	wire        sclk;
	wire        sdi;
	wire        fs_n;
	wire  [7:0] code;
	wire        powered;
	wire        ready;
	int         mismatches = 0;
	int         checked = 0;
	int         cyc = 0;
	logic [7:0] exp_q = 8'h00;
	logic [7:0] w;
	// model: every complete word in arrival order
	logic [7:0] done_q[$];
	always #5 clock = ~clock;
	sdcl_host u_sdcl_host (
		.sclk (sclk),
		.sdi  (sdi),
		.fs_n (fs_n)
	);
	sdcl_serial_dac_code_loader u_sdcl_serial_dac_code_loader (
		.clock          (clock),
		.nrst           (nrst),
		.serial_clk     (sclk),
		.serial_data_in (sdi),
		.frame_sel_n    (fs_n),
		.load_dac_n     (ld_n),
		.dac_code_r     (code),
		.if_powered_r   (powered),
		.word_ready_r   (ready)
	);
	task chk(input string name, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", name, e, s);
		end
	endtask
	task give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// the whole run needs about 1120 cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict;
		end
	end
	initial begin
		void'($urandom(32'hbd58));
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		chk("code", code, exp_q);
		chk("powered", {7'h00, powered}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			w = 8'($urandom);
			@(posedge clock);
			ld_n <= i[0];
			u_sdcl_host.send(w);
			done_q.push_back(w);
			if (!i[0])
				exp_q = done_q[$];
			chk("code", code, exp_q);
			chk("ready", {7'h00, ready}, 8'h01);
			chk("powered", {7'h00, powered}, 8'h00);
			@(posedge clock);
			ld_n <= 1'b0;
			repeat (6) @(posedge clock);
			#1;
			exp_q = done_q[$];
			chk("code", code, exp_q);
		end
		w = 8'($urandom);
		@(posedge clock);
		ld_n <= 1'b1;
		u_sdcl_host.stray(w);
		chk("ready", {7'h00, ready}, 8'h01);
		@(posedge clock);
		ld_n <= 1'b0;
		repeat (6) @(posedge clock);
		#1;
		chk("code", code, done_q[$]);
		give_verdict;
	end
endmodule // sdcl_serial_dac_code_loader_tb
`default_nettype wire
